// ### design/srh_host.sv
`timescale 1ns/1ps
// Behaviour
// [R1] 256 words of 4 bits, 8-bit address
// [R2] write: direction high, write_select low
// [R3] read: direction low, write_select high
// [R4] deselected device ignores access, floats pins
// [R5] device floats within 100 ns of release
// [R6] direction high 20 ns before write data
// [R7] read cycle spacing and access time
// [R8] write cycle and pulse minimum widths
// [R9] retention keeps data at low supply
// [R10] select_low_one held high during retention
// [R11] wait one read cycle after retention
// [R12] direction high and write_select high: idle
module srh_host (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [srh_pkg::ADDR_W-1:0] req_addr_in,
  input wire logic [srh_pkg::DATA_W-1:0] req_wdata_in,
  input wire logic standby_in,
  output logic req_ready_out,
  output logic rd_valid_out,
  output logic [srh_pkg::DATA_W-1:0] rd_data_out,
  output srh_pkg::srh_pins_s pins_out,
  input wire logic [srh_pkg::DATA_W-1:0] data_pin_in,
  output logic [srh_pkg::DATA_W-1:0] data_pin_out,
  output logic data_pin_oe_out
);
  // ==========================================================
  // state
  srh_pkg::srh_state_e state_r; // sequencer
  logic [srh_pkg::CNT_W-1:0] cnt_r; // cycles spent in the phase
  logic [srh_pkg::DATA_W-1:0] wdata_r; // held write word
  // run lengths for the long timing checks, all saturating at their top value
  logic [srh_pkg::CNT_W-1:0] strobe_len_r; // edges seen with write_select low
  logic [srh_pkg::CNT_W-1:0] read_len_r; // edges seen with direction low
  logic [srh_pkg::CNT_W-1:0] quiet_len_r; // edges since direction last went high

  // ==========================================================
  // sequencer; phases end on cycle counts, never on device feedback
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= srh_pkg::SRH_IDLE;
      cnt_r <= '0;
      wdata_r <= '0;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      unique case (state_r)
        srh_pkg::SRH_IDLE: begin
          cnt_r <= '0;
          if (standby_in) begin
            state_r <= srh_pkg::SRH_STBY; // [R10]
          end else if (req_valid_in) begin
            wdata_r <= req_wdata_in;
            state_r <= req_write_in ? srh_pkg::SRH_WDIR : srh_pkg::SRH_RD;
          end
        end
        srh_pkg::SRH_RD: begin
          // sample at the end of a full read cycle [R7]
          if (cnt_r == 8'(srh_pkg::READ_CYCLES - 1)) begin
            cnt_r <= '0;
            state_r <= srh_pkg::SRH_RFLOAT;
          end
        end
        srh_pkg::SRH_RFLOAT: begin
          // give the device its float delay before anyone drives [R5]
          if (cnt_r == 8'(srh_pkg::FLOAT_CYCLES - 1)) begin
            state_r <= srh_pkg::SRH_IDLE;
          end
        end
        srh_pkg::SRH_WDIR: begin
          // direction and address settle before data and strobe [R6]
          if (cnt_r == 8'(srh_pkg::DIR_CYCLES - 1)) begin
            cnt_r <= '0;
            state_r <= srh_pkg::SRH_WPULSE;
          end
        end
        srh_pkg::SRH_WPULSE: begin
          if (cnt_r == 8'(srh_pkg::WPULSE_CYCLES - 1)) begin // [R8]
            cnt_r <= '0;
            state_r <= srh_pkg::SRH_WREC;
          end
        end
        srh_pkg::SRH_WREC: begin
          // pad so strobe pulse plus recovery last the write cycle time [R8]
          if (cnt_r == 8'(srh_pkg::WRITE_CYCLES - srh_pkg::WPULSE_CYCLES - 1)) begin
            state_r <= srh_pkg::SRH_IDLE;
          end
        end
        srh_pkg::SRH_STBY: begin
          // recovery: stay deselected one read cycle after wake [R11]
          if (standby_in) begin
            cnt_r <= '0;
          end else if (cnt_r == 8'(srh_pkg::READ_CYCLES - 1)) begin
            state_r <= srh_pkg::SRH_IDLE;
          end
        end
        default: state_r <= srh_pkg::SRH_IDLE;
      endcase
    end
  end

  // ==========================================================
  // pin drive, registered from the current state: pins trail the sequencer by one cycle, except the address, loaded at the same edge as the request
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pins_out <= '{addr: '0, write_select: 1'b1, io_direction_control: 1'b1,
                    select_low_one: 1'b1, select_low_two: 1'b1};
      data_pin_out <= '0;
      data_pin_oe_out <= 1'b0;
    end else begin
      // idle default: deselected, write_select high, direction high [R12]
      pins_out.write_select <= 1'b1;
      pins_out.io_direction_control <= 1'b1;
      pins_out.select_low_one <= 1'b1;
      pins_out.select_low_two <= 1'b1;
      data_pin_oe_out <= 1'b0;
      if (state_r == srh_pkg::SRH_IDLE && req_valid_in && !standby_in) begin
        pins_out.addr <= req_addr_in; // [R1]
      end
      unique case (state_r)
        srh_pkg::SRH_RD: begin
          // read: direction low, write_select high [R3]
          pins_out.io_direction_control <= 1'b0;
          pins_out.select_low_one <= 1'b0;
          pins_out.select_low_two <= 1'b0;
        end
        srh_pkg::SRH_WDIR, srh_pkg::SRH_WPULSE, srh_pkg::SRH_WREC: begin
          pins_out.select_low_one <= 1'b0;
          pins_out.select_low_two <= 1'b0;
          // strobe and data only after the direction setup [R2] [R6]
          pins_out.write_select <= !(state_r == srh_pkg::SRH_WPULSE);
          data_pin_oe_out <= (state_r != srh_pkg::SRH_WDIR);
          data_pin_out <= wdata_r;
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // answers to the user side
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      req_ready_out <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out <= '0;
    end else begin
      req_ready_out <= 1'b0;
      rd_valid_out <= 1'b0;
      if (state_r == srh_pkg::SRH_IDLE && req_valid_in && !standby_in) begin
        req_ready_out <= 1'b1;
      end
      if (state_r == srh_pkg::SRH_RD && cnt_r == 8'(srh_pkg::READ_CYCLES - 1)) begin
        rd_valid_out <= 1'b1; // [R7]
        rd_data_out <= data_pin_in;
      end
    end
  end

  // ==========================================================
  // checks
  a_write_dir_setup: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(data_pin_oe_out) |-> pins_out.io_direction_control
      && $past(pins_out.io_direction_control)) // [R6]
    else $error("write data driven without direction setup");
  a_no_contention: assert property (@(posedge mclk_in) disable iff (rst_in)
    data_pin_oe_out |-> pins_out.io_direction_control) // [R4]
    else $error("host drives while device may drive");
  a_read_pins: assert property (@(posedge mclk_in) disable iff (rst_in)
    !pins_out.io_direction_control |-> pins_out.write_select
      && !pins_out.select_low_one) // [R3]
    else $error("read pins inconsistent");
  a_write_strobe_dir: assert property (@(posedge mclk_in) disable iff (rst_in)
    !pins_out.write_select |-> pins_out.io_direction_control && data_pin_oe_out) // [R2]
    else $error("write strobe without input direction");
  a_write_pulse_len: assert property (@(posedge mclk_in) disable iff (rst_in)
    $fell(pins_out.write_select) |-> !pins_out.write_select [*8]) // [R8]
    else $error("write pulse too short");
  a_read_spacing: assert property (@(posedge mclk_in) disable iff (rst_in)
    $fell(pins_out.io_direction_control) |-> !pins_out.io_direction_control [*8]) // [R7]
    else $error("read cycle too short");
  a_float_gap: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(pins_out.io_direction_control) |-> !data_pin_oe_out [*8]) // [R5]
    else $error("drive before device float delay");
  a_standby_desel: assert property (@(posedge mclk_in) disable iff (rst_in)
    state_r == srh_pkg::SRH_STBY |=> pins_out.select_low_one) // [R10]
    else $error("select asserted in retention");
  a_wake_wait: assert property (@(posedge mclk_in) disable iff (rst_in)
    $fell(standby_in) && state_r == srh_pkg::SRH_STBY |-> !req_ready_out [*8]) // [R11]
    else $error("access too soon after retention");

  // ==========================================================
  // run-length counters for checks longer than a repetition can span
  // write pulse length so far; saturates rather than wrapping to a short count
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      strobe_len_r <= '0;
    end else if (pins_out.write_select) begin
      strobe_len_r <= '0; // strobe idle
    end else if (strobe_len_r != '1) begin
      strobe_len_r <= strobe_len_r + 8'h01; // strobe still low
    end
  end

  // how long the device has been asked to drive in the current read
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      read_len_r <= '0;
    end else if (pins_out.io_direction_control) begin
      read_len_r <= '0; // pins are inputs
    end else if (read_len_r != '1) begin
      read_len_r <= read_len_r + 8'h01; // read still open
    end
  end

  // time since the last read let go; starts saturated since no read precedes reset
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      quiet_len_r <= '1;
    end else if (!pins_out.io_direction_control) begin
      quiet_len_r <= '0; // device may be driving
    end else if (quiet_len_r != '1) begin
      quiet_len_r <= quiet_len_r + 8'h01; // device floating out
    end
  end

  a_strobe_width: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(pins_out.write_select) |-> strobe_len_r >= 8'(srh_pkg::WPULSE_CYCLES)) // [R8]
    else $error("write pulse shorter than its minimum");
  a_read_access: assert property (@(posedge mclk_in) disable iff (rst_in)
    rd_valid_out |-> read_len_r >= 8'(srh_pkg::READ_CYCLES - 1)) // [R7]
    else $error("read word taken before access time");
  a_float_wait: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(data_pin_oe_out) |-> quiet_len_r >= 8'(srh_pkg::FLOAT_CYCLES)) // [R5] [R6]
    else $error("host drives before the device has let go");
endmodule : srh_host

// ### design/srh_pkg.sv
package srh_pkg;
  // ==========================================================
  // geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 4;
  // ==========================================================
  // timing, nanoseconds as printed (slowest grade by default)
  localparam int CLK_PERIOD_NS = 4;
  localparam int READ_CYCLE_NS = 450;
  localparam int WRITE_CYCLE_NS = 270;
  localparam int WRITE_PULSE_NS = 250;
  localparam int DIR_SETUP_NS = 20;
  localparam int ADDR_SETUP_NS = 20;
  localparam int FLOAT_DELAY_NS = 100;
  // least times round up to whole cycles
  localparam int READ_CYCLES = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYCLES = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPULSE_CYCLES = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIR_CYCLES = (DIR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ASU_CYCLES = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYCLES = (FLOAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  // ==========================================================
  // pins toward the memory
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic write_select;
    logic io_direction_control;
    logic select_low_one;
    logic select_low_two;
  } srh_pins_s;
  typedef enum logic [2:0] {
    SRH_IDLE, SRH_RD, SRH_RFLOAT, SRH_WDIR, SRH_WPULSE, SRH_WREC, SRH_STBY
  } srh_state_e;
endpackage : srh_pkg

// ### dv/srh_mem_model.sv
`timescale 1ns/1ps
// ==========================================
// behavioural static memory on the host's far side
module srh_mem_model (
  input wire srh_pkg::srh_pins_s pins_in,
  input wire logic [srh_pkg::DATA_W-1:0] data_in,
  output logic [srh_pkg::DATA_W-1:0] data_out
);
  // contents are never cleared, so standby keeps them
  logic [srh_pkg::DATA_W-1:0] mem [256];
  logic [srh_pkg::DATA_W-1:0] last = 4'h0; // last word driven
  logic sel; // both selects low
  logic drive; // model owns the data lines
  // either select high deselects the part
  assign sel = !pins_in.select_low_one && !pins_in.select_low_two;
  // drives only on a selected read; floats at once otherwise
  assign drive = sel && !pins_in.io_direction_control && pins_in.write_select;
  // released lines show the inverse, so a late sample cannot pass
  assign data_out = drive ? mem[pins_in.addr] : ~last;
  // remember what was on the lines when they let go
  always @(negedge drive) last = mem[pins_in.addr];
  // word taken as write_select rises, data still held then; selects are read
  // straight from the pins so a reset that drops them in the same step writes nothing
  always @(posedge pins_in.write_select) begin
    if (!pins_in.select_low_one && !pins_in.select_low_two
        && pins_in.io_direction_control) begin
      mem[pins_in.addr] <= data_in;
    end
  end
endmodule : srh_mem_model

// ### dv/test_srh_host.sv
`timescale 1ns/1ps
// ==========================================
// host bench: table of accesses, then standby and reset cases
module test_srh_host;
  typedef struct packed {logic w; logic [7:0] a; logic [3:0] d;} srh_row_s;
  logic mclk_in = 0, rst_in = 1, req_valid_in = 0, req_write_in = 0, standby_in = 0;
  logic [7:0] req_addr_in = 8'h00;
  logic [3:0] req_wdata_in = 4'h0, host_d, dev_d, wire_d;
  logic req_ready_out, rd_valid_out, oe;
  logic [3:0] rd_data_out;
  logic [3:0] exp_mem [256]; // reference contents
  srh_pkg::srh_pins_s pins;
  int n_fail = 0, num_checks = 0, i, k;
  // back-to-back writes, boundary addresses, then overwrite
  srh_row_s rows [8] = '{'{1, 8'h00, 4'h5}, '{1, 8'hFF, 4'hA}, '{1, 8'h80, 4'h3},
    '{0, 8'h00, 4'h0}, '{0, 8'hFF, 4'h0}, '{0, 8'h80, 4'h0}, '{1, 8'h00, 4'hC},
    '{0, 8'h00, 4'h0}};
  // host wins the wire while enabled, the model otherwise
  assign wire_d = oe ? host_d : dev_d;
  srh_host uut (.mclk_in(mclk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
    .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .standby_in(standby_in), .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .pins_out(pins), .data_pin_in(wire_d),
    .data_pin_out(host_d), .data_pin_oe_out(oe));
  srh_mem_model dev (.pins_in(pins), .data_in(wire_d), .data_out(dev_d));
  // 250 MHz clock
  initial begin
    forever #2 mclk_in = ~mclk_in;
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  // one edge, then settle before touching inputs
  task automatic tick;
    @(posedge mclk_in);
    #1;
  endtask : tick
  // bounded wait on ready or read-valid; a lapse ends the run
  task automatic wait_for(input bit rd);
    for (k = 0; k < 300 && (rd ? rd_valid_out : req_ready_out) !== 1'b1; k++) tick();
    if (k == 300) begin
      check("handshake timeout", 8'h01, 8'h00);
      give_verdict();
    end
  endtask : wait_for
  // request held until the ready pulse, dropped in that cycle
  task automatic op(input srh_row_s r);
    req_write_in = r.w;
    req_addr_in = r.a;
    req_wdata_in = r.d;
    req_valid_in = 1;
    wait_for(0);
    req_valid_in = 0;
    // pins follow the sequencer one cycle after the ready pulse
    tick();
    check("address", pins.addr, r.a);
    check("direction", pins.io_direction_control, r.w);
    check("select one", pins.select_low_one, 0);
    check("select two", pins.select_low_two, 0);
    check("strobe idle", pins.write_select, 1);
    check("early drive", oe, 0);
    if (r.w) begin
      exp_mem[r.a] = r.d;
      // direction setup spent: strobe and data are out now
      repeat (srh_pkg::DIR_CYCLES) tick();
      check("strobe", pins.write_select, 0);
      check("write drive", oe, 1);
      check("write word", host_d, r.d);
    end else begin
      wait_for(1);
      check("read latency", 8'(k), 8'(srh_pkg::READ_CYCLES - 1));
      check("read word", rd_data_out, exp_mem[r.a]);
    end
  endtask : op
  initial begin
    repeat (12) tick();
    rst_in = 0;
    check("idle select", pins.select_low_one, 1);
    check("idle drive", oe, 0);
    for (i = 0; i < 8; i++) op(rows[i]);
    // standby: held deselected, a request must wait
    standby_in = 1;
    // let the last read's float time run out so the loop below sees retention
    repeat (30) tick();
    req_valid_in = 1;
    for (i = 0; i < 20; i++) begin
      tick();
      check("standby ready", req_ready_out, 0);
      check("standby select", pins.select_low_one, 1);
    end
    standby_in = 0;
    for (i = 0; i < 300 && req_ready_out !== 1'b1; i++) tick();
    check("wake wait", i >= srh_pkg::READ_CYCLES, 1);
    check("wake time", 8'(i), 8'(srh_pkg::READ_CYCLES + 1));
    req_valid_in = 0;
    wait_for(1);
    check("after standby", rd_data_out, exp_mem[8'h00]);
    // reset in mid-write: pins must let go at once, then work again
    op(srh_row_s'{1'b1, 8'h80, 4'h9});
    rst_in = 1;
    tick();
    check("reset select", pins.select_low_one, 1);
    check("reset strobe", pins.write_select, 1);
    check("reset drive", oe, 0);
    rst_in = 0;
    op(rows[4]);
    give_verdict();
  end
endmodule : test_srh_host
